// File: pkg/rst_regs.svh
// register offsets, field positions, reset values and timing constants
`ifndef RST_REGS_SVH
`define RST_REGS_SVH
`define RST_ADDR_LATENCY 8'h35
`define RST_ADDR_WINDOW 8'h36
`define RST_ADDR_INACT 8'h37
`define RST_ADDR_CTRL1 8'h38
`define RST_ADDR_CTRL2 8'h39
`define RST_ADDR_WAKESRC 8'h3A
`define RST_RESET_BYTE 8'h00
`define RST_CTRL1_RSVD_MASK 8'hDF
`define RST_CTRL2_MASK 8'h03
`define RST_STANDBY 2'h0
`define RST_WAKE_GATE_BIT 7
// microseconds per millisecond, time per step in microseconds, and clock in kHz
`define RST_US_PER_MS 32'd1000
`define RST_STEP_US_MIN 32'd625
`define RST_INACT_STEP_US 32'd320000
`define RST_INACT_STEP_SLOW_US 32'd640000
`define RST_CLK_KHZ 32'd25000
// sample period in microseconds per rate index (400,200,100,50,25,12.5,1.56 Hz)
`define RST_PER_400 32'd2500
`define RST_PER_200 32'd5000
`define RST_PER_100 32'd10000
`define RST_PER_50 32'd20000
`define RST_PER_25 32'd40000
`define RST_PER_12 32'd80000
`define RST_PER_1 32'd640000
`endif

// File: pkg/rst_pkg.sv
// types shared by the rate, sleep and tap timing block
package rst_pkg;
	typedef enum logic [2:0] {
		RST_R400 = 3'h0,
		RST_R200 = 3'h1,
		RST_R100 = 3'h2,
		RST_R50 = 3'h3,
		RST_R12 = 3'h4,
		RST_R1 = 3'h5,
		RST_R25 = 3'h6
	} rst_rate_t;
	typedef struct packed {
		logic [1:0] sleep_sample_rate;
		logic zero;
		logic [2:0] active_rate_select;
		logic [1:0] scale_mode_select;
	} rst_ctrl1_t;
	typedef struct packed {
		logic transient;
		logic orient;
		logic tap;
		logic motion1;
		logic motion2;
		logic fifo;
	} rst_act_t;
	typedef enum logic [3:0] {
		RST_T_IDLE = 4'h1,
		RST_T_LAT = 4'h2,
		RST_T_WIN = 4'h4,
		RST_T_SEC = 4'h8
	} rst_tap_st_t;
endpackage

// File: hw/rst_tick_gen.sv
// sample-tick generator: one pulse per period of the selected rate
`timescale 1ns/1ps
`include "rst_regs.svh"
module rst_tick_gen #(
	parameter int CLK_KHZ = 25000
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// control
	input wire logic run_i,
	input wire logic restart_i,
	input wire logic [31:0] period_us_i,
	// tick out
	output logic tick_o
);
	logic [31:0] cnt_q, cnt_d, limit;
	logic [63:0] prod;
	logic tick_q, tick_d;

	// cycle count of one period, at least one cycle; the product is formed
	// wide because the slowest period times the full clock overflows 32 bits
	always_comb begin
		prod = {32'h0, period_us_i} * 64'(CLK_KHZ);
		limit = 32'(prod / 64'(`RST_US_PER_MS));
		if (limit == 32'h0) begin
			limit = 32'h1;
		end
		cnt_d = cnt_q;
		tick_d = 1'b0;
		if (!run_i || restart_i) begin
			cnt_d = 32'h0;
		end else if (cnt_q + 32'h1 >= limit) begin
			cnt_d = 32'h0;
			tick_d = 1'b1;
		end else begin
			cnt_d = cnt_q + 32'h1;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q <= 32'h0;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end
	assign tick_o = tick_q;
endmodule // rst_tick_gen

// File: hw/rst_step_timer.sv
// step timer: counts a programmed number of steps of a given length
`timescale 1ns/1ps
`include "rst_regs.svh"
module rst_step_timer #(
	parameter int CLK_KHZ = 25000
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// control
	input wire logic start_i,
	input wire logic stop_i,
	input wire logic [31:0] step_us_i,
	input wire logic [7:0] steps_i,
	// status
	output logic busy_o,
	output logic done_o
);
	logic [31:0] sub_q, sub_d, limit;
	logic [7:0] left_q, left_d;
	logic busy_q, busy_d, done_q, done_d;

	// a value of n gives n whole steps; zero finishes at once
	always_comb begin
		limit = (step_us_i * 32'(CLK_KHZ)) / `RST_US_PER_MS;
		if (limit == 32'h0) begin
			limit = 32'h1;
		end
		sub_d = sub_q;
		left_d = left_q;
		busy_d = busy_q;
		done_d = 1'b0;
		if (stop_i) begin
			busy_d = 1'b0;
		end else if (start_i) begin
			sub_d = 32'h0;
			left_d = steps_i;
			busy_d = (steps_i != 8'h00);
			done_d = (steps_i == 8'h00);
		end else if (busy_q) begin
			if (sub_q + 32'h1 >= limit) begin
				sub_d = 32'h0;
				left_d = left_q - 8'h01;
				if (left_q == 8'h01) begin
					busy_d = 1'b0;
					done_d = 1'b1;
				end
			end else begin
				sub_d = sub_q + 32'h1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sub_q <= 32'h0;
			left_q <= 8'h00;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			sub_q <= sub_d;
			left_q <= left_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end
	assign busy_o = busy_q;
	assign done_o = done_q;
endmodule // rst_step_timer

// File: hw/rst_rate_sleep_tap.sv
// rate select, auto-sleep control and tap timing, with its byte registers
`timescale 1ns/1ps
`include "rst_regs.svh"
module rst_rate_sleep_tap #(
	parameter int CLK_KHZ = 25000
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// register port
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// activity from functional blocks
	input wire rst_pkg::rst_act_t activity_i,
	input wire logic [4:0] wake_enable_i,
	input wire logic sleep_irq_enable_i,
	input wire logic fifo_empty_i,
	// pulse detector raw events
	input wire logic pulse_start_i,
	input wire logic pulse_end_i,
	input wire logic [7:0] pulse_limit_i,
	input wire logic double_enable_i,
	// outputs
	output logic sample_tick_o,
	output logic asleep_o,
	output logic active_o,
	output logic [1:0] scale_o,
	output logic low_power_o,
	output logic fifo_flush_o,
	output logic fifo_gate_o,
	output logic block_reset_o,
	output logic sleep_irq_o,
	output logic single_tap_o,
	output logic double_tap_o
);
	////////////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] lat_q, lat_d, win_q, win_d, inact_q, inact_d, ctl2_q, ctl2_d;
	logic gate_q, gate_d;
	rst_pkg::rst_ctrl1_t ctl1_q, ctl1_d;

	// byte writes; bit 5 of control one always reads zero
	always_comb begin
		lat_d = lat_q;
		win_d = win_q;
		inact_d = inact_q;
		ctl1_d = ctl1_q;
		ctl2_d = ctl2_q;
		gate_d = gate_q;
		if (reg_we_i) begin
			case (reg_addr_i)
				`RST_ADDR_LATENCY: lat_d = reg_wdata_i;
				`RST_ADDR_WINDOW: win_d = reg_wdata_i;
				`RST_ADDR_INACT: inact_d = reg_wdata_i;
				`RST_ADDR_CTRL1: ctl1_d = reg_wdata_i & `RST_CTRL1_RSVD_MASK;
				`RST_ADDR_CTRL2: ctl2_d = reg_wdata_i & `RST_CTRL2_MASK;
				`RST_ADDR_WAKESRC: gate_d = reg_wdata_i[`RST_WAKE_GATE_BIT];
				default: ;
			endcase
		end
	end

	// all registers reset to zero, so rate 000 and standby
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lat_q <= `RST_RESET_BYTE;
			win_q <= `RST_RESET_BYTE;
			inact_q <= `RST_RESET_BYTE;
			ctl1_q <= `RST_RESET_BYTE;
			ctl2_q <= `RST_RESET_BYTE;
			gate_q <= 1'b0;
		end else begin
			lat_q <= lat_d;
			win_q <= win_d;
			inact_q <= inact_d;
			ctl1_q <= ctl1_d;
			ctl2_q <= ctl2_d;
			gate_q <= gate_d;
		end
	end

	// read mux, registered for a steady data output
	logic [7:0] rd_d, rd_q;
	logic asleep_q, asleep_d;
	always_comb begin
		case (reg_addr_i)
			`RST_ADDR_LATENCY: rd_d = lat_q;
			`RST_ADDR_WINDOW: rd_d = win_q;
			`RST_ADDR_INACT: rd_d = inact_q;
			`RST_ADDR_CTRL1: rd_d = ctl1_q;
			`RST_ADDR_CTRL2: rd_d = ctl2_q;
			`RST_ADDR_WAKESRC: rd_d = {gate_q, 7'h00};
			default: rd_d = 8'h00;
		endcase
		if (!reg_re_i) begin
			rd_d = rd_q;
		end
	end
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_q <= 8'h00;
		end else begin
			rd_q <= rd_d;
		end
	end
	assign reg_rdata_o = rd_q;

	////////////////////////////////////////////////////////////////////////////////
	// rate decode
	logic auto_sleep_enable, lowp, active;
	assign auto_sleep_enable = ctl2_q[1];
	assign lowp = ctl2_q[0];
	assign active = (ctl1_q.scale_mode_select != `RST_STANDBY);

	// sleep-rate code to internal rate index
	function automatic rst_pkg::rst_rate_t sleep_rate(input logic [1:0] c);
		case (c)
			2'h0: sleep_rate = rst_pkg::RST_R50;
			2'h1: sleep_rate = rst_pkg::RST_R25;
			2'h2: sleep_rate = rst_pkg::RST_R12;
			default: sleep_rate = rst_pkg::RST_R1;
		endcase
	endfunction

	// sample period of a rate index
	function automatic logic [31:0] period_us(input rst_pkg::rst_rate_t r);
		case (r)
			rst_pkg::RST_R400: period_us = `RST_PER_400;
			rst_pkg::RST_R200: period_us = `RST_PER_200;
			rst_pkg::RST_R100: period_us = `RST_PER_100;
			rst_pkg::RST_R50: period_us = `RST_PER_50;
			rst_pkg::RST_R25: period_us = `RST_PER_25;
			rst_pkg::RST_R12: period_us = `RST_PER_12;
			default: period_us = `RST_PER_1;
		endcase
	endfunction

	// pulse step: base 0.625 ms doubling down to 50 Hz, then held; low power doubles.
	// latency and window use twice the limit base, with 20 ms low power at 100 Hz
	function automatic logic [31:0] tap_step(input rst_pkg::rst_rate_t r, input logic lp,
		input logic lat);
		logic [31:0] s;
		s = `RST_STEP_US_MIN;
		case (r)
			rst_pkg::RST_R400: s = `RST_STEP_US_MIN;
			rst_pkg::RST_R200: s = `RST_STEP_US_MIN << 1;
			rst_pkg::RST_R100: s = `RST_STEP_US_MIN << 2;
			default: s = `RST_STEP_US_MIN << 3;
		endcase
		if (lat) begin
			s = s << 1;
		end
		if (lp) begin
			s = s << 1;
		end
		if (lat && lp && r == rst_pkg::RST_R100) begin
			s = s << 1;
		end
		tap_step = s;
	endfunction

	rst_pkg::rst_rate_t act_rate, cur_rate;
	// asleep overrides every block's rate
	always_comb begin
		act_rate = rst_pkg::rst_rate_t'(ctl1_q.active_rate_select);
		if (ctl1_q.active_rate_select > 3'h5) begin
			act_rate = rst_pkg::RST_R1;
		end
		cur_rate = asleep_q ? sleep_rate(ctl1_q.sleep_sample_rate) : act_rate;
	end

	logic transition;
	rst_tick_gen #(.CLK_KHZ(CLK_KHZ)) u_tick (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.run_i(active),
		.restart_i(transition),
		.period_us_i(period_us(cur_rate)),
		.tick_o(sample_tick_o)
	);

	////////////////////////////////////////////////////////////////////////////////
	// auto-sleep: inactivity counter in clock cycles of 320/640 ms steps
	logic [31:0] isub_q, isub_d, ilim;
	logic [7:0] istep_q, istep_d;
	logic keep_awake, wake_hit, irq_q, irq_d;
	// fifo keeps awake but is not a wake source; interrupts are not inputs
	assign keep_awake = |activity_i;
	assign wake_hit = |({activity_i.transient, activity_i.orient, activity_i.tap,
		activity_i.motion1, activity_i.motion2} & wake_enable_i);

	always_comb begin
		ilim = ((cur_rate == rst_pkg::RST_R1) ? `RST_INACT_STEP_SLOW_US : `RST_INACT_STEP_US)
			/ `RST_US_PER_MS * 32'(CLK_KHZ);
		isub_d = isub_q;
		istep_d = istep_q;
		asleep_d = asleep_q;
		transition = 1'b0;
		if (!active || !auto_sleep_enable) begin
			asleep_d = 1'b0; // without auto-sleep only the mode field matters
			isub_d = 32'h0;
			istep_d = 8'h00;
		end else if (asleep_q) begin
			if (wake_hit) begin
				asleep_d = 1'b0;
				transition = 1'b1;
				isub_d = 32'h0;
				istep_d = 8'h00;
			end
		end else if (keep_awake) begin
			isub_d = 32'h0;
			istep_d = 8'h00;
		end else if (istep_q >= inact_q) begin
			asleep_d = 1'b1;
			transition = 1'b1;
			isub_d = 32'h0;
			istep_d = 8'h00;
		end else if (isub_q + 32'h1 >= ilim) begin
			isub_d = 32'h0;
			istep_d = istep_q + 8'h01;
		end else begin
			isub_d = isub_q + 32'h1;
		end
		irq_d = transition && sleep_irq_enable_i;
	end

	// fifo gate holds input blocked from a transition until emptied
	logic fgate_q, fgate_d, flush_q, flush_d;
	logic breset_q, breset_d;
	always_comb begin
		fgate_d = fgate_q;
		flush_d = transition && !gate_q;
		breset_d = transition; // counters reset even when the gate keeps the fifo
		if (transition && gate_q) begin
			fgate_d = 1'b1;
		end else if (fifo_empty_i) begin
			fgate_d = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			isub_q <= 32'h0;
			istep_q <= 8'h00;
			asleep_q <= 1'b0;
			irq_q <= 1'b0;
			fgate_q <= 1'b0;
			flush_q <= 1'b0;
			breset_q <= 1'b0;
		end else begin
			isub_q <= isub_d;
			istep_q <= istep_d;
			asleep_q <= asleep_d;
			irq_q <= irq_d;
			fgate_q <= fgate_d;
			flush_q <= flush_d;
			breset_q <= breset_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// tap timing: latency, then second-pulse window
	rst_pkg::rst_tap_st_t st_q, st_d;
	logic lat_start, lat_done, win_start, win_done, lim_start, lim_busy;
	logic single_q, single_d, dbl_q, dbl_d;

	rst_step_timer #(.CLK_KHZ(CLK_KHZ)) u_lat (
		.clk_i(clk_i), .rstn_i(rstn_i), .start_i(lat_start), .stop_i(transition),
		.step_us_i(tap_step(cur_rate, lowp, 1'b1)), .steps_i(lat_q),
		.busy_o(), .done_o(lat_done));
	rst_step_timer #(.CLK_KHZ(CLK_KHZ)) u_win (
		.clk_i(clk_i), .rstn_i(rstn_i), .start_i(win_start), .stop_i(transition),
		.step_us_i(tap_step(cur_rate, lowp, 1'b1)), .steps_i(win_q),
		.busy_o(), .done_o(win_done));
	rst_step_timer #(.CLK_KHZ(CLK_KHZ)) u_lim (
		.clk_i(clk_i), .rstn_i(rstn_i), .start_i(lim_start), .stop_i(transition),
		.step_us_i(tap_step(cur_rate, lowp, 1'b0)), .steps_i(pulse_limit_i),
		.busy_o(lim_busy), .done_o());

	always_comb begin
		st_d = st_q;
		lat_start = 1'b0;
		win_start = 1'b0;
		lim_start = 1'b0;
		single_d = 1'b0;
		dbl_d = 1'b0;
		case (st_q)
			rst_pkg::RST_T_IDLE: if (pulse_end_i && active) begin
				lat_start = 1'b1; // first pulse qualified upstream
				single_d = 1'b1;
				st_d = rst_pkg::RST_T_LAT;
			end
			rst_pkg::RST_T_LAT: if (lat_done) begin // pulses ignored here
				st_d = double_enable_i ? rst_pkg::RST_T_WIN : rst_pkg::RST_T_IDLE;
				win_start = double_enable_i;
			end
			rst_pkg::RST_T_WIN: if (pulse_start_i) begin
				lim_start = 1'b1; // start must fall in window
				st_d = rst_pkg::RST_T_SEC;
			end else if (win_done) begin
				st_d = rst_pkg::RST_T_IDLE;
			end
			rst_pkg::RST_T_SEC: if (pulse_end_i) begin
				dbl_d = lim_busy; // end may pass the window, width must fit
				st_d = rst_pkg::RST_T_IDLE;
			end else if (!lim_busy) begin
				st_d = rst_pkg::RST_T_IDLE;
			end
			default: st_d = rst_pkg::RST_T_IDLE;
		endcase
		if (transition) begin
			st_d = rst_pkg::RST_T_IDLE;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q <= rst_pkg::RST_T_IDLE;
			single_q <= 1'b0;
			dbl_q <= 1'b0;
		end else begin
			st_q <= st_d;
			single_q <= single_d;
			dbl_q <= dbl_d;
		end
	end

	// outputs
	assign asleep_o = asleep_q;
	assign active_o = active;
	assign scale_o = ctl1_q.scale_mode_select;
	assign low_power_o = lowp;
	assign fifo_flush_o = flush_q;
	assign fifo_gate_o = fgate_q;
	assign block_reset_o = breset_q;
	assign sleep_irq_o = irq_q;
	assign single_tap_o = single_q;
	assign double_tap_o = dbl_q;
endmodule // rst_rate_sleep_tap

// File: bench/rst_rate_sleep_tap_sva.sv
// assertion checker for the rate, sleep and tap timing block
`timescale 1ns/1ps
module rst_rate_sleep_tap_sva #(
	parameter int CLK_KHZ = 25000
) (
	// clock, reset and register strobes
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	input wire logic [7:0] reg_rdata_o,
	// activity and tap inputs
	input wire rst_pkg::rst_act_t activity_i,
	input wire logic [4:0] wake_enable_i,
	input wire logic sleep_irq_enable_i,
	input wire logic pulse_end_i,
	input wire logic double_enable_i,
	// watched outputs
	input wire logic sample_tick_o,
	input wire logic asleep_o,
	input wire logic active_o,
	input wire logic fifo_flush_o,
	input wire logic fifo_gate_o,
	input wire logic block_reset_o,
	input wire logic sleep_irq_o,
	input wire logic single_tap_o,
	input wire logic double_tap_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// fifo is left out: it keeps the part awake but never wakes it
	logic wake_hit;
	assign wake_hit = |(activity_i[5:1] & wake_enable_i);
	sequence s_quiet;
		!sample_tick_o [*8];
	endsequence
	sequence s_woken;
		##[1:2] !asleep_o;
	endsequence
	AST_TRANS_FLUSH: assert property ($changed(asleep_o) |->
		block_reset_o && (fifo_flush_o || fifo_gate_o))
		else $error("no flush or counter reset on a sleep change");
	AST_FLUSH_CAUSE: assert property (fifo_flush_o |-> $changed(asleep_o))
		else $error("flush without a sleep change");
	AST_IRQ_ON: assert property (sleep_irq_enable_i && $changed(asleep_o) |-> sleep_irq_o)
		else $error("sleep interrupt missing on a transition");
	AST_IRQ_CAUSE: assert property (sleep_irq_o |-> $changed(asleep_o))
		else $error("sleep interrupt without a transition");
	AST_NO_FIFO_WAKE: assert property (asleep_o && !wake_hit && !reg_we_i |=> asleep_o)
		else $error("woke without an enabled wake source");
	AST_WAKE: assert property (asleep_o && wake_hit |-> s_woken)
		else $error("enabled wake source did not wake");
	AST_TICK_GAP: assert property (sample_tick_o |=> s_quiet)
		else $error("sample ticks too close together");
	AST_STANDBY_QUIET: assert property ((!active_o) [*2] |-> !sample_tick_o)
		else $error("sample tick in standby");
	AST_SINGLE_CAUSE: assert property (single_tap_o |-> $past(pulse_end_i))
		else $error("single tap without a pulse end");
	AST_DOUBLE_CAUSE: assert property (double_tap_o |->
		$past(pulse_end_i) && $past(double_enable_i))
		else $error("double tap without cause");
	AST_RDATA_HOLD: assert property (!$past(reg_re_i) |-> $stable(reg_rdata_o))
		else $error("read data moved without a read");
endmodule // rst_rate_sleep_tap_sva

bind rst_rate_sleep_tap rst_rate_sleep_tap_sva #(.CLK_KHZ(CLK_KHZ)) rst_rate_sleep_tap_sva_inst (
	.clk_i(clk_i), .rstn_i(rstn_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
	.reg_rdata_o(reg_rdata_o), .activity_i(activity_i), .wake_enable_i(wake_enable_i),
	.sleep_irq_enable_i(sleep_irq_enable_i), .pulse_end_i(pulse_end_i),
	.double_enable_i(double_enable_i), .sample_tick_o(sample_tick_o), .asleep_o(asleep_o),
	.active_o(active_o), .fifo_flush_o(fifo_flush_o), .fifo_gate_o(fifo_gate_o),
	.block_reset_o(block_reset_o),
	.sleep_irq_o(sleep_irq_o), .single_tap_o(single_tap_o), .double_tap_o(double_tap_o));

// File: bench/rst_host_model.sv
// host processor model: drives the byte register port
`timescale 1ns/1ps
`include "rst_regs.svh"
module rst_host_model (
	// clock
	input wire logic clk_i,
	// register port
	output logic reg_we_o,
	output logic reg_re_o,
	output logic [7:0] reg_addr_o,
	output logic [7:0] reg_wdata_o,
	input wire logic [7:0] reg_rdata_i
);
	// port idle from time zero
	initial begin
		reg_we_o = 1'b0;
		reg_re_o = 1'b0;
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
	end
	// one byte write; mode changes come through here, apart from the bench's reset back to standby
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_we_o <= 1'b1;
		reg_addr_o <= a;
		reg_wdata_o <= d;
		@(posedge clk_i);
		reg_we_o <= 1'b0;
		reg_wdata_o <= ~d; // released data must not keep showing the old byte
	endtask
	// one byte read, data taken the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		reg_re_o <= 1'b1;
		reg_addr_o <= a;
		@(posedge clk_i);
		reg_re_o <= 1'b0;
		@(posedge clk_i);
		#1;
		d = reg_rdata_i;
	endtask
	// latency is programmed before single and double tap use alike
	task automatic set_latency(input logic [7:0] v);
		wr(`RST_ADDR_LATENCY, v);
	endtask
endmodule // rst_host_model

// File: bench/rst_rate_sleep_tap_tb.sv
// self-checking testbench for the rate, sleep and tap timing block
`timescale 1ns/1ps
`include "rst_regs.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
	$display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end
module rst_rate_sleep_tap_tb;
	localparam int CLK_KHZ = 25; // shrinks every timer a thousandfold
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic reg_we_i, reg_re_i;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
	rst_pkg::rst_act_t activity_i = '0;
	logic [4:0] wake_enable_i = 5'h1F;
	logic sleep_irq_enable_i = 1'b1;
	logic fifo_empty_i = 1'b1;
	logic pulse_start_i = 1'b0;
	logic pulse_end_i = 1'b0;
	logic [7:0] pulse_limit_i = 8'h08;
	logic double_enable_i = 1'b0;
	logic sample_tick_o, asleep_o, active_o, low_power_o, fifo_flush_o, fifo_gate_o;
	logic block_reset_o, sleep_irq_o, single_tap_o, double_tap_o;
	logic [1:0] scale_o;
	int fail_count = 0;
	int cmp_count = 0;
	logic [7:0] shadow [logic [7:0]]; // bench model of the register file
	logic [15:0] lfsr_q = 16'hD3AE;
	logic s, d;
	int n;
	int cnt [3] = '{0, 1, 1};
	int cyc [3] = '{1, 8000, 16000}; // inactivity steps in cycles at the reduced clock
	logic [7:0] ctl [3] = '{8'h01, 8'h45, 8'h95};
	int aper [2] = '{`RST_PER_400, `RST_PER_200}; // awake periods of ctl 0 and 1
	int sper [3] = '{`RST_PER_50, `RST_PER_25, `RST_PER_12}; // sleep periods per ctl
	// 25 MHz clock
	always #20 clk_i = ~clk_i;
	rst_host_model rst_host_model_inst (.clk_i(clk_i), .reg_we_o(reg_we_i), .reg_re_o(reg_re_i),
		.reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o));
	rst_rate_sleep_tap #(.CLK_KHZ(CLK_KHZ)) rst_rate_sleep_tap_inst (.clk_i(clk_i),
		.rstn_i(rstn_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .activity_i(activity_i),
		.wake_enable_i(wake_enable_i), .sleep_irq_enable_i(sleep_irq_enable_i),
		.fifo_empty_i(fifo_empty_i), .pulse_start_i(pulse_start_i), .pulse_end_i(pulse_end_i),
		.pulse_limit_i(pulse_limit_i), .double_enable_i(double_enable_i),
		.sample_tick_o(sample_tick_o), .asleep_o(asleep_o), .active_o(active_o),
		.scale_o(scale_o), .low_power_o(low_power_o), .fifo_flush_o(fifo_flush_o),
		.fifo_gate_o(fifo_gate_o), .block_reset_o(block_reset_o), .sleep_irq_o(sleep_irq_o),
		.single_tap_o(single_tap_o), .double_tap_o(double_tap_o));
	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	// writable bits per address; unmapped places keep nothing
	function automatic logic [7:0] rmask(input logic [7:0] a);
		case (a)
			`RST_ADDR_LATENCY, `RST_ADDR_WINDOW, `RST_ADDR_INACT: return 8'hFF;
			`RST_ADDR_CTRL1: return `RST_CTRL1_RSVD_MASK;
			`RST_ADDR_CTRL2: return `RST_CTRL2_MASK;
			`RST_ADDR_WAKESRC: return 8'h80;
			default: return 8'h00;
		endcase
	endfunction
	task automatic wrm(input logic [7:0] a, input logic [7:0] v);
		rst_host_model_inst.wr(a, v);
		shadow[a] = v & rmask(a);
	endtask
	task automatic rchk(input logic [7:0] a);
		logic [7:0] v;
		rst_host_model_inst.rd(a, v);
		`CHK(v, shadow.exists(a) ? shadow[a] : 8'h00)
	endtask
	// one pulse of the given width; results sampled after the end is taken
	task automatic tap(input int w, output logic so, output logic dso);
		@(posedge clk_i);
		pulse_start_i <= 1'b1;
		@(posedge clk_i);
		pulse_start_i <= 1'b0;
		repeat (w) @(posedge clk_i);
		pulse_end_i <= 1'b1;
		@(posedge clk_i);
		pulse_end_i <= 1'b0;
		#1;
		so = single_tap_o;
		dso = double_tap_o;
	endtask
	// cycles between two sample ticks; a lost tick ends the run
	task automatic tick_gap(output int k);
		int w;
		w = 0;
		k = 0;
		while (sample_tick_o !== 1'b1 && w < 5000) begin
			@(posedge clk_i);
			#1;
			w++;
		end
		do begin
			@(posedge clk_i);
			#1;
			k++;
		end while (sample_tick_o !== 1'b1 && k < 5000);
		if (w >= 5000 || k >= 5000) begin
			fail_count++;
			$display("[ERR] t=%0t got=%0h exp=%0h", $time, k, 0);
			wrap_up();
		end
	endtask
	task automatic wait_sleep(input logic lvl, input int bound, output int k);
		k = 0;
		while (asleep_o !== lvl) begin
			@(posedge clk_i);
			#1;
			k++;
			if (k > bound) begin
				fail_count++;
				$display("[ERR] t=%0t got=%0h exp=%0h", $time, asleep_o, lvl);
				wrap_up();
			end
		end
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (12) @(posedge clk_i);
		rstn_i <= 1'b1;
		for (int a = 'h35; a <= 'h39; a++) rchk(8'(a));
		rchk(8'h40);
		repeat (3) begin
			for (int a = 'h35; a <= 'h37; a++) begin
				lfsr_q = lfsr_next(lfsr_q);
				wrm(8'(a), lfsr_q[7:0]);
				rchk(8'(a));
			end
		end
		wrm(8'h38, 8'hFE);
		rchk(8'h38);
		wrm(8'h39, 8'hFF);
		rchk(8'h39);
		`CHK(low_power_o, 1'b1)
		for (int m = 0; m < 4; m++) begin
			wrm(8'h38, 8'(m));
			#1;
			`CHK(active_o, 1'(m != 0))
			`CHK(scale_o, 2'(m))
		end
		// latency step doubles in low power: a second tap at 360 cycles passes only in normal
		rst_host_model_inst.set_latency(8'h08);
		wrm(8'h36, 8'h08);
		for (int lp = 0; lp < 2; lp++) begin
			wrm(8'h39, 8'(lp));
			tap(2, s, d);
			`CHK(s, 1'b1)
			repeat (360) @(posedge clk_i);
			tap(2, s, d);
			`CHK(s, 1'(lp == 0))
			repeat (700) @(posedge clk_i);
		end
		wrm(8'h39, 8'h00);
		double_enable_i <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			tap(2, s, d);
			`CHK(s, 1'b1)
			repeat (k == 1 ? 700 : 360) @(posedge clk_i);
			tap(k == 2 ? 250 : 3, s, d);
			`CHK(d, 1'(k == 0))
			repeat (900) @(posedge clk_i);
		end
		// auto-sleep off: quiet never sleeps
		@(posedge clk_i);
		double_enable_i <= 1'b0;
		wrm(8'h37, 8'h00);
		repeat (300) @(posedge clk_i);
		#1;
		`CHK(asleep_o, 1'b0)
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_i);
			activity_i <= rst_pkg::rst_act_t'(6'h20);
			fifo_empty_i <= 1'(i != 2);
			wrm(8'h37, 8'(cnt[i]));
			wrm(8'h38, ctl[i]);
			wrm(`RST_ADDR_WAKESRC, (i == 2) ? 8'h80 : 8'h00);
			wrm(8'h39, 8'h02);
			if (i < 2) begin
				tick_gap(n);
				`CHK(n, aper[i] * CLK_KHZ / `RST_US_PER_MS)
			end
			@(posedge clk_i);
			activity_i <= '0;
			wait_sleep(1'b1, cyc[i] + 300, n);
			`CHK(n >= cyc[i] - 100 && n <= cyc[i] + 100, 1'b1)
			`CHK(sleep_irq_o, 1'b1)
			`CHK(fifo_flush_o, 1'(i != 2))
			`CHK(block_reset_o, 1'b1)
			`CHK(fifo_gate_o, 1'(i == 2))
			tick_gap(n);
			`CHK(n, sper[i] * CLK_KHZ / `RST_US_PER_MS)
			@(posedge clk_i);
			activity_i <= rst_pkg::rst_act_t'(6'h01);
			fifo_empty_i <= 1'b1;
			repeat (50) @(posedge clk_i);
			#1;
			`CHK(asleep_o, 1'b1)
			`CHK(fifo_gate_o, 1'b0)
			@(posedge clk_i);
			activity_i <= rst_pkg::rst_act_t'(6'h20);
			wake_enable_i <= 5'h00;
			repeat (50) @(posedge clk_i);
			#1;
			`CHK(asleep_o, 1'b1)
			@(posedge clk_i);
			wake_enable_i <= 5'h1F;
			wait_sleep(1'b0, 3, n);
			`CHK(block_reset_o, 1'b1)
			wrm(8'h39, 8'h00);
		end
		// second reset in mid-run brings the control byte back to zero
		@(posedge clk_i);
		rstn_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		rstn_i <= 1'b1;
		shadow.delete();
		rchk(8'h38);
		`CHK(active_o, 1'b0)
		wrap_up();
	end
endmodule // rst_rate_sleep_tap_tb
